// File: hw/efp_if.sv
`timescale 1ns/1ns
interface efp_if;
  logic [8:0] ext_input_word;
  logic       ext_input_write_strobe_n;
  logic       ext_input_space_avail;
  modport router (input ext_input_word, input ext_input_write_strobe_n,
                  output ext_input_space_avail);
  modport writer (output ext_input_word, output ext_input_write_strobe_n,
                  input ext_input_space_avail);
endinterface : efp_if

// File: hw/efp_pkg.sv
package efp_pkg;
  // Word layout: flag in bit 8, data byte in bits 7..0, msb is bit 7
  localparam int WORD_W    = 9;
  localparam int FLAG_BIT  = 8;
  localparam int BYTE_MSB  = 7;
  localparam int TERM_BIT  = 0;
  localparam int FIFO_DEPTH = 16;
  // Word kinds
  typedef enum logic [1:0] {EFP_DATA, EFP_EOP, EFP_EEP} efp_kind_t;

  // Classify a word by its flag and terminator bits
  function automatic efp_kind_t word_kind(input logic [WORD_W-1:0] w);
    if (!w[FLAG_BIT])
      return EFP_DATA;
    else if (w[TERM_BIT])
      return EFP_EEP;
    else
      return EFP_EOP;
  endfunction : word_kind
endpackage : efp_pkg

// File: hw/efp_router_in.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Nine-bit word; flag clear carries data byte
// - Flag set: bit0 clear EOP, set EEP
// - Bit 7 is the data byte msb
// - Space indication high until FIFO holds DEPTH-1 words
// - Strobe low pushes presented word while a slot is free
module efp_router_in #(
  parameter int DEPTH = efp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         srst,
  // Link to writer
  efp_if.router                             link,
  // Drain side
  output logic [efp_pkg::WORD_W-1:0]        rd_word,
  output efp_pkg::efp_kind_t                rd_kind,
  output logic [7:0]                        rd_byte,
  output logic                              rd_valid,
  input  wire logic                         rd_ready,
  output logic                              overrun_err
);
  // Timing of one word across the link, counted in clock edges:
  //   edge 0: writer takes a user beat and drops its strobe
  //   edge 1: strobe sampled low here, word stored, count rises
  //   edge 2: rd_valid and the new head are seen by the drain
  // The writer shares this clock, so the link needs no resynchroniser;
  // a filtering synchroniser would also swallow single-cycle strobes
  // and break the promise of one word for every low strobe cycle that finds a free slot.

  // Limits a user must know:
  //   DEPTH must be at least 2, so a word can still be taken after
  //   space is withdrawn; a power of two keeps the index logic small.
  //   Terminator bits 7..1 are stored as given and ignored on decode.
  //   A writer that strobes with space low loses that word only once
  //   storage is truly full, and overrun_err records the loss.

  // Derived widths; the fill count needs one bit more than a pointer
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // Fill levels: storage full, and the level at which space is withdrawn
  localparam logic [CW-1:0] FULL_LVL  = CW'(DEPTH);
  localparam logic [CW-1:0] CLOSE_LVL = CW'(DEPTH - 1);
  // Last slot index, where the ring pointers wrap
  localparam logic [AW-1:0] LAST_IDX  = AW'(DEPTH - 1);

  // Storage and its bookkeeping
  logic [efp_pkg::WORD_W-1:0] mem_reg [DEPTH];
  logic [AW-1:0]              wr_ptr_reg;
  logic [AW-1:0]              wr_ptr_next;
  logic [AW-1:0]              rd_ptr_reg;
  logic [AW-1:0]              rd_ptr_next;
  logic [CW-1:0]              count_reg;
  logic [CW-1:0]              count_next;

  // Per-cycle events on the link and the drain
  logic                       strobe_low;
  logic                       room;
  logic                       push;
  logic                       pop;
  logic                       full;
  logic                       overrun_next;

  // Advance a ring index, wrapping after the last slot
  function automatic logic [AW-1:0] ring_step(
    input logic [AW-1:0] idx
  );
    if (idx == LAST_IDX)
    begin
      return '0;
    end
    else
    begin
      return idx + 1'b1;
    end
  endfunction : ring_step

  // New fill level from this cycle's push and pop
  function automatic logic [CW-1:0] fill_step(
    input logic [CW-1:0] level,
    input logic          add,
    input logic          sub
  );
    logic [CW-1:0] result;
    result = level;
    if (add && !sub)
    begin
      result = level + 1'b1;
    end
    else if (sub && !add)
    begin
      result = level - 1'b1;
    end
    return result;
  endfunction : fill_step

  // Strobe is active low and sampled straight from the link
  assign strobe_low = !link.ext_input_write_strobe_n;

  // Free slot test shared by the push and the overrun flag
  assign room = (count_reg != FULL_LVL);
  // Each cycle with a low strobe and a free slot takes one word
  assign push = strobe_low && room;
  // Drain takes the head word when it says it is ready
  assign pop  = rd_valid && rd_ready;

  // Space is withdrawn one word early: the writer registers its strobe,
  // so a word it accepts on the last open cycle still finds a slot
  assign full = (count_reg >= CLOSE_LVL);
  assign link.ext_input_space_avail = !full;

  // Storage write; slots need no reset since rd_valid guards the head
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= link.ext_input_word;
    end
  end

  // Next pointer and fill values
  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push)
    begin
      wr_ptr_next = ring_step(wr_ptr_reg);
    end
    if (pop)
    begin
      rd_ptr_next = ring_step(rd_ptr_reg);
    end
    count_next = fill_step(count_reg, push, pop);
  end

  // Write pointer
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  // Read pointer
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rd_ptr_reg <= '0;
    end
    else
    begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Fill count; a push and a pop in one cycle leave it unchanged
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // A low strobe met with no free slot means the writer broke the
  // handshake; the word is dropped, as overwriting would corrupt a packet
  assign overrun_next = strobe_low && !room;

  // Sticky flag, cleared only by reset
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      overrun_err <= 1'b0;
    end
    else if (overrun_next)
    begin
      overrun_err <= 1'b1;
    end
  end

  // Head word is valid whenever anything is stored
  assign rd_valid = (count_reg != '0);

  // Head word, decoded kind and data byte with bit 7 as msb;
  // decoded from the storage flops so the drain sees no extra latency
  always_comb
  begin
    rd_word = mem_reg[rd_ptr_reg];
    rd_kind = efp_pkg::word_kind(rd_word);
    rd_byte = rd_word[efp_pkg::BYTE_MSB:0];
  end
endmodule : efp_router_in

// File: hw/efp_writer.sv
`timescale 1ns/1ns
module efp_writer (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // Link to router
  efp_if.writer                      link,
  // User side
  input  wire logic                  usr_valid,
  input  wire efp_pkg::efp_kind_t    usr_kind,
  input  wire logic [7:0]            usr_byte,
  output logic                       usr_ready
);
  logic       space_ok;
  logic [8:0] word_reg;
  logic       strobe_n_reg;

  // Space comes from logic on this clock, so it is used directly;
  // the router withdraws it a word early to cover our strobe register
  assign space_ok  = link.ext_input_space_avail;
  assign usr_ready = space_ok;

  // Build and strobe one word per accepted user beat
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      strobe_n_reg <= 1'b1;
      word_reg     <= 9'h000;
    end
    else
    begin
      strobe_n_reg <= !(usr_valid && space_ok);
      if (usr_valid && space_ok)
        unique case (usr_kind)
          efp_pkg::EFP_DATA: word_reg <= {1'b0, usr_byte};
          efp_pkg::EFP_EOP:  word_reg <= 9'h100;
          efp_pkg::EFP_EEP:  word_reg <= 9'h101;
          default:           word_reg <= 9'h101;
        endcase
    end
  end
  assign link.ext_input_word           = word_reg;
  assign link.ext_input_write_strobe_n = strobe_n_reg;
endmodule : efp_writer

// File: tb/efp_link_sva.sv
`timescale 1ns/1ns
module efp_link_sva (
  // Clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // Link signals
  input wire logic [8:0] ext_input_word,
  input wire logic       ext_input_write_strobe_n,
  input wire logic       ext_input_space_avail
);
  // Short aliases keep each property but a_term_bits_zero on one line
  wire sn = ext_input_write_strobe_n;
  wire sp = ext_input_space_avail;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_term_bits_zero: assert property (!sn && ext_input_word[8] |->
    ext_input_word[7:1] == 7'h00) else $error("terminator upper bits set");
  a_space_after_reset: assert property ($fell(srst) |-> sp)
    else $error("no space after reset");
  a_strobe_idle_reset: assert property ($fell(srst) |-> sn)
    else $error("strobe active after reset");
  a_space_falls_push: assert property ($fell(sp) |-> !$past(sn))
    else $error("space fell without a write");
  a_no_strobe_full: assert property (!sp |=> sn)
    else $error("write while full");
  a_strobe_has_space: assert property (!sn |-> $past(sp))
    else $error("strobe without prior space");
  // Data and error-end traffic and the full condition
  c_data: cover property (!sn && !ext_input_word[8]);
  c_eep: cover property (!sn && ext_input_word[8] && ext_input_word[0]);
  c_full: cover property ($fell(sp));
endmodule : efp_link_sva

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic               clock = 0;
  logic               srst = 1;
  logic               usr_valid = 0;
  logic               rd_ready = 0;
  efp_pkg::efp_kind_t usr_kind = efp_pkg::EFP_DATA;
  logic [7:0]         usr_byte = 8'h00;
  logic               usr_ready, rd_valid, overrun_err;
  logic [8:0]         rd_word, e;
  efp_pkg::efp_kind_t rd_kind;
  logic [7:0]         rd_byte;
  int                 err_count = 0, n_checks = 0, t;
  logic [8:0]         q[$];
  // Free-running 100 MHz clock
  always #5 clock = ~clock;
  efp_if link ();
  efp_writer efp_writer_inst (.clock(clock), .srst(srst), .link(link.writer),
    .usr_valid(usr_valid), .usr_kind(usr_kind), .usr_byte(usr_byte),
    .usr_ready(usr_ready));
  efp_router_in #(.DEPTH(16)) efp_router_in_inst (.clock(clock), .srst(srst),
    .link(link.router), .rd_word(rd_word), .rd_kind(rd_kind),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .overrun_err(overrun_err));
  efp_link_sva efp_link_sva_inst (.clock(clock), .srst(srst),
    .ext_input_word(link.ext_input_word),
    .ext_input_write_strobe_n(link.ext_input_write_strobe_n),
    .ext_input_space_avail(link.ext_input_space_avail));
  task automatic chk(string nm, logic [8:0] x, logic [8:0] g);
    n_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Kinds cycle data, data, data, end, error end; bytes keep the msb set
  task automatic send(int i);
    logic [7:0] b;
    b = 8'h80 ^ 8'(i);
    @(posedge clock);
    usr_valid <= 1'b1;
    usr_kind <= efp_pkg::efp_kind_t'(i % 5 < 3 ? 0 : i % 5 - 2);
    usr_byte <= b;
    t = 0;
    do @(negedge clock); while (usr_ready !== 1'b1 && ++t < 50);
    if (t >= 50)
    begin
      err_count++;
      give_verdict();
    end
    @(posedge clock);
    usr_valid <= 1'b0;
    q.push_back(i % 5 < 3 ? {1'b0, b} : {1'b1, 7'h00, i % 5 == 4});
  endtask : send
  // Fill with the drain stalled until refused, then drain and compare
  initial
  begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 30; i++)
    begin
      repeat (2) @(negedge clock);
      if (usr_ready !== 1'b1)
        break;
      send(i);
    end
    repeat (10) @(posedge clock);
    chk("space", 9'h000, 9'(link.ext_input_space_avail));
    @(posedge clock);
    rd_ready <= 1'b1;
    for (t = 0; q.size() > 0 && t < 200; t++)
    begin
      @(negedge clock);
      if (rd_valid === 1'b1)
      begin
        e = q.pop_front();
        chk("word", e, rd_word);
        chk("kind", 9'(e[8] ? (e[0] ? 2 : 1) : 0), 9'(rd_kind));
        chk("byte", 9'(e[7:0]), 9'(rd_byte));
      end
    end
    chk("left", 9'h000, 9'(q.size()));
    chk("space", 9'h001, 9'(link.ext_input_space_avail));
    chk("overrun", 9'h000, 9'(overrun_err));
    give_verdict();
  end
endmodule : tb
